// ==== pkg/pxoca_pkg.sv ====
// Constants for the pixel output and clock alignment block.
// Assumes a single 100 MHz system clock and byte-wide register access.
package pxoca_pkg;
	// Sample and buffer geometry
	localparam int SAMPLE_W     = 10;
	localparam int WORD_W       = 3 * SAMPLE_W + 1;
	localparam int SYNC_W       = WORD_W + 1;
	// Cycles from the sampling instant to launch at the output
	localparam int LAUNCH_DELAY = 2;
	// Register offsets
	localparam logic [7:0] OFS_SAMPLING_PHASE  = 8'h04;
	localparam logic [7:0] OFS_OUT_CLOCK_SEL   = 8'h20;
	localparam logic [7:0] OFS_LINE_SYNC_CTRL  = 8'h21;
	localparam logic [7:0] OFS_LINE_SYNC_WIDTH = 8'h22;
	localparam logic [7:0] OFS_PIXEL_PERIOD    = 8'h23;
	// Reset values
	localparam logic [7:0] RST_SAMPLING_PHASE  = 8'h00;
	localparam logic [7:0] RST_OUT_CLOCK_SEL   = 8'h00;
	localparam logic [7:0] RST_LINE_SYNC_CTRL  = 8'h00;
	localparam logic [7:0] RST_LINE_SYNC_WIDTH = 8'h20;
	// Field positions
	localparam int CLK_SEL_MSB  = 7;
	localparam int CLK_SEL_LSB  = 6;
	localparam int PHASE_MSB    = 4;
	localparam int LS_OUT_INV   = 0;
	localparam int LS_IN_LOW    = 1;
	// Strobe clock forms
	typedef enum logic [1:0] {
		FORM_PIXEL  = 2'h0,
		FORM_QUAD   = 2'h1,
		FORM_DOUBLE = 2'h2,
		FORM_HALF   = 2'h3
	} pxoca_form_t;
endpackage : pxoca_pkg

// ==== rtl/pxoca_buf2.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on clk; reset is synchronous and active high.
`timescale 1ns/1ps
module pxoca_buf2 #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem [2];
	logic         wptr_reg;
	logic         rptr_reg;
	logic [1:0]   count_reg;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = mem[rptr_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem[wptr_reg] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wptr_reg  <= 1'b0;
			rptr_reg  <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			wptr_reg  <= wptr_reg ^ push;
			rptr_reg  <= rptr_reg ^ pop;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : pxoca_buf2

// ==== rtl/pxoca_top.sv ====
// Pixel output stage: samples three colour buses at a programmable phase
// of the incoming sample clock, forwards them with a fixed latency until a launch meets out_ready low, and
// makes a strobe clock and regenerated line sync aligned to the data.
// Assumes the sample clock is far slower than clk (about 8 MHz).
`timescale 1ns/1ps
// Summary of operation
// [R1] Each colour output bus is ten bits wide with bit 9 as the MSB.
// [R2] Samples leave at a fixed latency from their sampling instant; after a stalled launch the code adds a pixel period.
// [R3] A new sampling phase moves the sampling instant and output timing.
// [R4] Strobe clock and line sync move together with the colour outputs.
// [R5] Bits 7 to 6 of the output clock register pick the strobe form.
// [R6] Three forms are pixel, pixel shifted 90 degrees and double rate.
// [R7] The fourth form is an internally made half-rate pixel clock.
// [R8] Downstream logic registers data and line sync on the strobe.
// [R9] Line sync is regenerated hsync, aligned, with set polarity/width.
module pxoca_top (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// Register port
	input  wire logic                         reg_write,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	output logic      [7:0]                   reg_rdata,
	// Sampling side
	input  wire logic                         external_sample_clock,
	input  wire logic [pxoca_pkg::SAMPLE_W-1:0] red_in,
	input  wire logic [pxoca_pkg::SAMPLE_W-1:0] green_in,
	input  wire logic [pxoca_pkg::SAMPLE_W-1:0] blue_in,
	input  wire logic                         hsync_in,
	// Output side
	output logic [pxoca_pkg::SAMPLE_W-1:0]    red_sample_out,
	output logic [pxoca_pkg::SAMPLE_W-1:0]    green_sample_out,
	output logic [pxoca_pkg::SAMPLE_W-1:0]    blue_sample_out,
	output logic                              data_strobe_clock,
	output logic                              line_sync_out,
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic                              sample_dropped
);
	localparam int SW = pxoca_pkg::SAMPLE_W;
	localparam int WW = pxoca_pkg::WORD_W;
	localparam int YW = pxoca_pkg::SYNC_W;

	// Register file
	logic [7:0] phase_reg;
	logic [7:0] clk_sel_reg;
	logic [7:0] ls_ctrl_reg;
	logic [7:0] ls_width_reg;
	logic [7:0] period_reg;
	logic [7:0] rdata_next;

	wire wr_phase = reg_write & (reg_addr == pxoca_pkg::OFS_SAMPLING_PHASE);
	wire wr_sel   = reg_write & (reg_addr == pxoca_pkg::OFS_OUT_CLOCK_SEL);
	wire wr_lsc   = reg_write & (reg_addr == pxoca_pkg::OFS_LINE_SYNC_CTRL);
	wire wr_lsw   = reg_write & (reg_addr == pxoca_pkg::OFS_LINE_SYNC_WIDTH);

	always_comb begin
		unique case (reg_addr)
			pxoca_pkg::OFS_SAMPLING_PHASE:  rdata_next = phase_reg;
			pxoca_pkg::OFS_OUT_CLOCK_SEL:   rdata_next = clk_sel_reg;
			pxoca_pkg::OFS_LINE_SYNC_CTRL:  rdata_next = ls_ctrl_reg;
			pxoca_pkg::OFS_LINE_SYNC_WIDTH: rdata_next = ls_width_reg;
			pxoca_pkg::OFS_PIXEL_PERIOD:    rdata_next = period_reg;
			default:                        rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			phase_reg    <= pxoca_pkg::RST_SAMPLING_PHASE;
			clk_sel_reg  <= pxoca_pkg::RST_OUT_CLOCK_SEL;
			ls_ctrl_reg  <= pxoca_pkg::RST_LINE_SYNC_CTRL;
			ls_width_reg <= pxoca_pkg::RST_LINE_SYNC_WIDTH;
			reg_rdata    <= 8'h00;
		end else begin
			if (wr_phase)
				phase_reg <= reg_wdata;
			if (wr_sel)
				clk_sel_reg <= reg_wdata;
			if (wr_lsc)
				ls_ctrl_reg <= reg_wdata;
			if (wr_lsw)
				ls_width_reg <= reg_wdata;
			reg_rdata <= rdata_next;
		end
	end

	// Pin synchroniser: clock, hsync and colour buses, three stages
	logic [YW-1:0] in_s1_reg;
	logic [YW-1:0] in_s2_reg;
	logic [YW-1:0] in_s3_reg;
	logic          ck_level_reg;

	always_ff @(posedge clk) begin
		in_s1_reg <= {external_sample_clock, hsync_in, red_in, green_in,
			blue_in};
		in_s2_reg <= in_s1_reg;
		in_s3_reg <= in_s2_reg;
	end

	wire ck_agree = (in_s2_reg[YW-1] == in_s3_reg[YW-1]);
	wire ck_rise  = ck_agree & in_s3_reg[YW-1] & ~ck_level_reg;

	// Phase counter and pixel period measurement
	logic [7:0] ph_cnt_reg;
	wire  [7:0] phase_req = {3'h0, phase_reg[pxoca_pkg::PHASE_MSB:0]};
	wire  [7:0] period_m1 = period_reg - 8'h01;
	// Phase beyond one pixel would never sample; clamp to the last cycle
	wire  [7:0] phase_eff = (phase_req < period_reg) ? phase_req : period_m1;
	// [R3] Phase sets instant
	wire        capture   = (ph_cnt_reg == phase_eff) & (period_reg != 8'h00);

	always_ff @(posedge clk) begin
		if (reset) begin
			ck_level_reg <= 1'b0;
			ph_cnt_reg   <= 8'hff;
			period_reg   <= 8'h00;
		end else begin
			if (ck_agree)
				ck_level_reg <= in_s3_reg[YW-1];
			if (ck_rise) begin
				ph_cnt_reg <= 8'h00;
				period_reg <= ph_cnt_reg + 8'h01;
			end else if (ph_cnt_reg != 8'hff) begin
				ph_cnt_reg <= ph_cnt_reg + 8'h01;
			end
		end
	end

	// Hsync leading edge, travelling with its pixel
	// Raw level is kept so a polarity change makes no false lead
	wire  hs_raw  = in_s3_reg[YW-2];
	wire  hs_pol  = ls_ctrl_reg[pxoca_pkg::LS_IN_LOW];
	wire  hs_now  = hs_raw ^ hs_pol;
	logic hs_prev_reg;
	wire  hs_lead = hs_now & ~(hs_prev_reg ^ hs_pol);

	always_ff @(posedge clk) begin
		if (reset)
			hs_prev_reg <= 1'b0;
		else if (capture)
			hs_prev_reg <= hs_raw;
	end

	// [R2] Fixed launch delay
	logic [pxoca_pkg::LAUNCH_DELAY-1:0] launch_pipe_reg;
	wire launch = launch_pipe_reg[pxoca_pkg::LAUNCH_DELAY-1];

	always_ff @(posedge clk) begin
		if (reset)
			launch_pipe_reg <= '0;
		else
			launch_pipe_reg <= {launch_pipe_reg[pxoca_pkg::LAUNCH_DELAY-2:0],
				capture};
	end

	// Buffer keeps a word when the receiver stalls at launch
	logic          buf_in_ready;
	logic          buf_out_valid;
	logic [WW-1:0] buf_out_data;
	wire           pop = launch & out_ready & buf_out_valid;

	pxoca_buf2 #(
		.W (WW)
	) u_buf (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (capture),
		.in_ready  (buf_in_ready),
		.in_data   ({hs_lead, in_s3_reg[WW-2:0]}),
		.out_valid (buf_out_valid),
		.out_ready (launch & out_ready),
		.out_data  (buf_out_data)
	);

	// Strobe clock generation relative to each launch
	logic [7:0] st_cnt_reg;
	logic       half_reg;
	logic       strobe_next;
	wire  [7:0] st_cnt_next = pop ? 8'h00 :
		((st_cnt_reg == 8'hff) ? st_cnt_reg : st_cnt_reg + 8'h01);
	wire        half_next   = half_reg ^ pop;
	wire  [7:0] t_half      = {1'b0, period_reg[7:1]};
	wire  [7:0] t_quarter   = {2'h0, period_reg[7:2]};
	wire  [7:0] t_three_q   = t_half + t_quarter;
	wire        in_first_h  = st_cnt_next < t_half;
	wire        in_mid      = (st_cnt_next >= t_quarter) &
		(st_cnt_next < t_three_q);
	wire        in_q0       = st_cnt_next < t_quarter;
	wire        in_q2       = (st_cnt_next >= t_half) &
		(st_cnt_next < t_three_q);
	wire pxoca_pkg::pxoca_form_t form_sel =
		pxoca_pkg::pxoca_form_t'(clk_sel_reg[pxoca_pkg::CLK_SEL_MSB:
			pxoca_pkg::CLK_SEL_LSB]);

	// [R5] Form select
	always_comb begin
		unique case (form_sel)
			// [R6] Pixel rate
			pxoca_pkg::FORM_PIXEL:  strobe_next = in_first_h;
			// [R6] Quarter shifted
			pxoca_pkg::FORM_QUAD:   strobe_next = in_mid;
			// [R6] Double rate
			pxoca_pkg::FORM_DOUBLE: strobe_next = in_q0 | in_q2;
			// [R7] Half rate
			pxoca_pkg::FORM_HALF:   strobe_next = half_next;
		endcase
	end

	// [R9] Line sync width
	logic [7:0] ls_cnt_reg;
	wire  [7:0] ls_cnt_next = !pop ? ls_cnt_reg :
		buf_out_data[WW-1] ? ls_width_reg :
		(ls_cnt_reg != 8'h00) ? ls_cnt_reg - 8'h01 : 8'h00;
	wire        ls_next = (ls_cnt_next != 8'h00) ^
		ls_ctrl_reg[pxoca_pkg::LS_OUT_INV];

	always_ff @(posedge clk) begin
		if (reset) begin
			st_cnt_reg <= 8'hff;
			half_reg   <= 1'b0;
			ls_cnt_reg <= 8'h00;
		end else begin
			st_cnt_reg <= st_cnt_next;
			half_reg   <= half_next;
			ls_cnt_reg <= ls_cnt_next;
		end
	end

	// Output register stage; all outputs advance on the same edge
	always_ff @(posedge clk) begin
		if (reset) begin
			red_sample_out    <= '0;
			green_sample_out  <= '0;
			blue_sample_out   <= '0;
			data_strobe_clock <= 1'b0;
			line_sync_out     <= 1'b0;
			out_valid         <= 1'b0;
			sample_dropped    <= 1'b0;
		end else begin
			// [R1] MSB at bit 9
			if (pop) begin
				red_sample_out   <= buf_out_data[3*SW-1:2*SW];
				green_sample_out <= buf_out_data[2*SW-1:SW];
				blue_sample_out  <= buf_out_data[SW-1:0];
			end
			// [R4] Aligned strobe, sync
			data_strobe_clock <= strobe_next;
			line_sync_out     <= ls_next;
			// [R8] Strobe marks data
			out_valid         <= pop;
			sample_dropped    <= capture & ~buf_in_ready;
		end
	end
endmodule : pxoca_top

// ==== verif/pxoca_props.sv ====
// Port checker for the pixel output stage.
// Assumes register writes reach the block only through its parallel port.
`timescale 1ns/1ps
module pxoca_props (
	// Clock and reset
	input wire logic                            clk,
	input wire logic                            reset,
	// Register port
	input wire logic                            reg_write,
	input wire logic [7:0]                      reg_addr,
	input wire logic [7:0]                      reg_wdata,
	input wire logic [7:0]                      reg_rdata,
	// Output side
	input wire logic [pxoca_pkg::SAMPLE_W-1:0] red_sample_out,
	input wire logic                            data_strobe_clock,
	input wire logic                            line_sync_out,
	input wire logic                            out_valid,
	input wire logic                            sample_dropped
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic [1:0] form_reg;
	logic [7:0] phase_reg;
	wire        wr_sel = reg_write && reg_addr == pxoca_pkg::OFS_OUT_CLOCK_SEL;
	wire        wr_ph  = reg_write && reg_addr == pxoca_pkg::OFS_SAMPLING_PHASE;
	wire        launch = out_valid;
	// Shadows of the written fields, kept apart from the design's copy
	always_ff @(posedge clk) begin
		if (reset) form_reg <= 2'h0;
		else if (wr_sel) form_reg <= reg_wdata[7:6];
	end
	always_ff @(posedge clk) begin
		if (reset) phase_reg <= 8'h00;
		else if (wr_ph) phase_reg <= reg_wdata;
	end
	sequence s_pulse;
		launch ##1 !launch;
	endsequence
	a_data_holds_between: assert property (
		!launch |-> $stable(red_sample_out)) else $error("data moved");
	a_valid_one_pulse: assert property (launch |-> s_pulse)
		else $error("out_valid too long");
	// Strobe level is made one cycle ahead, from the form then in force
	a_pixel_form_high: assert property (
		launch && $past(form_reg) == 2'h0 |-> data_strobe_clock)
		else $error("pixel form low at launch");
	a_quad_form_low: assert property (
		launch && $past(form_reg) == 2'h1 |-> !data_strobe_clock)
		else $error("quad form high at launch");
	a_double_form_high: assert property (
		launch && $past(form_reg) == 2'h2 |-> data_strobe_clock)
		else $error("double form low at launch");
	a_half_form_toggle: assert property (
		launch && $past(form_reg) == 2'h3 && $past(form_reg, 2) == 2'h3
		|-> data_strobe_clock != $past(data_strobe_clock))
		else $error("half form did not toggle");
	a_sync_moves_launch: assert property (
		!launch && !$past(reg_write) && !$past(reg_write, 2) |->
		$stable(line_sync_out)) else $error("line sync off launch");
	a_phase_read_back: assert property (
		$past(reg_addr) == pxoca_pkg::OFS_SAMPLING_PHASE |->
		reg_rdata == $past(phase_reg)) else $error("phase readback");
	a_unmapped_reads_zero: assert property (
		$past(reg_addr) == 8'h10 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_drop_one_pulse: assert property (
		sample_dropped |=> !sample_dropped) else $error("drop too long");
endmodule : pxoca_props
bind pxoca_top pxoca_props i_props (.clk, .reset, .reg_write, .reg_addr,
	.reg_wdata, .reg_rdata, .red_sample_out, .data_strobe_clock,
	.line_sync_out, .out_valid, .sample_dropped);

// ==== verif/pxoca_sink.sv ====
// Downstream capture model: registers data on strobe rising edges.
// Assumes the strobe is far slower than clk, so edges are seen by sampling.
`timescale 1ns/1ps
module pxoca_sink (
	// Clock and control
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        stall,
	// From the block
	input wire logic        data_strobe_clock,
	input wire logic [9:0]  red_sample_out,
	input wire logic        line_sync_out,
	output logic            out_ready,
	// Captured
	output logic [9:0]      cap_red,
	output logic            cap_sync,
	output int              rise_count
);
	logic strobe_q;
	assign out_ready = !stall;
	always @(posedge clk) begin
		strobe_q <= data_strobe_clock;
		if (reset) rise_count <= 0;
		else if (data_strobe_clock && !strobe_q) begin
			rise_count <= rise_count + 1;
			cap_red <= red_sample_out;
			cap_sync <= line_sync_out;
		end
	end
endmodule : pxoca_sink

// ==== verif/testbench.sv ====
// Self-checking bench for the pixel output stage.
// Assumes a free-running 8 MHz sample clock and a capture model downstream.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t %h %h", $time, a, b); end end
module testbench;
	logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, stall = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [9:0] red_in = 10'h000, green_in = 10'h3ff, blue_in = 10'h2aa;
	logic [9:0] red_sample_out, green_sample_out, blue_sample_out, cap_red;
	logic external_sample_clock = 1'b0, ext_q = 1'b0, hsync_in = 1'b0;
	logic hs_pend = 1'b0, data_strobe_clock, line_sync_out, cap_sync;
	logic out_valid, out_ready, sample_dropped;
	int err_total = 0, tests_run = 0, cyc = 0, rise_cyc = 0, rise_count;
	wire [9:0] nxt = red_in + 10'h089;
	pxoca_top i_dut (.clk, .reset, .reg_write, .reg_addr, .reg_wdata,
		.reg_rdata, .external_sample_clock, .red_in, .green_in, .blue_in,
		.hsync_in, .red_sample_out, .green_sample_out, .blue_sample_out,
		.data_strobe_clock, .line_sync_out, .out_valid, .out_ready,
		.sample_dropped);
	pxoca_sink i_sink (.clk, .reset, .stall, .data_strobe_clock,
		.red_sample_out, .line_sync_out, .out_ready, .cap_red, .cap_sync,
		.rise_count);
	always #5 clk = ~clk;
	// Offset start keeps sample edges off the clk edges
	initial begin
		#3;
		forever #62.5 external_sample_clock = ~external_sample_clock;
	end
	always @(posedge external_sample_clock) rise_cyc = cyc;
	// New pixel each sample period, held for the whole period
	always @(posedge clk) begin
		ext_q <= external_sample_clock;
		if (external_sample_clock && !ext_q) begin
			red_in <= nxt;
			green_in <= ~nxt;
			blue_in <= nxt ^ 10'h2aa;
			hsync_in <= hs_pend;
			hs_pend <= 1'b0;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk) reg_addr <= a;
		repeat (2) @(posedge clk);
		#1 v = reg_rdata;
	endtask : rd
	task automatic wait_launch(output int lat);
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			#1;
			if (out_valid === 1'b1) break;
		end
		lat = cyc - rise_cyc;
	endtask : wait_launch
	task automatic t_regs;
		logic [7:0] v;
		rd(pxoca_pkg::OFS_SAMPLING_PHASE, v);
		`CHK(v, pxoca_pkg::RST_SAMPLING_PHASE)
		rd(pxoca_pkg::OFS_OUT_CLOCK_SEL, v);
		`CHK(v, pxoca_pkg::RST_OUT_CLOCK_SEL)
		rd(pxoca_pkg::OFS_LINE_SYNC_WIDTH, v);
		`CHK(v, pxoca_pkg::RST_LINE_SYNC_WIDTH)
		rd(8'h10, v);
		`CHK(v, 8'h00)
		wr(pxoca_pkg::OFS_OUT_CLOCK_SEL, 8'hc0);
		rd(pxoca_pkg::OFS_OUT_CLOCK_SEL, v);
		`CHK(v, 8'hc0)
		wr(pxoca_pkg::OFS_OUT_CLOCK_SEL, 8'h00);
	endtask : t_regs
	task automatic t_latency;
		int a, b, c;
		logic [7:0] v;
		wait_launch(a);
		wait_launch(a);
		wait_launch(b);
		`CHK(a, b)
		`CHK(red_sample_out, red_in)
		`CHK({green_sample_out, blue_sample_out}, {green_in, blue_in})
		repeat (2) @(posedge clk);
		#1;
		`CHK(cap_red, red_sample_out)
		// Bench pixel period is 12.5 clk, so 12 or 13 is measured
		rd(pxoca_pkg::OFS_PIXEL_PERIOD, v);
		`CHK(v[7:1], 7'h06)
		wr(pxoca_pkg::OFS_SAMPLING_PHASE, 8'h02);
		repeat (3) wait_launch(c);
		`CHK(c - a, 2)
		wr(pxoca_pkg::OFS_SAMPLING_PHASE, 8'h00);
	endtask : t_latency
	task automatic t_forms;
		int exp_rises[4] = '{2, 2, 4, 1};
		int l, c0;
		for (int f = 0; f < 4; f++) begin
			wr(pxoca_pkg::OFS_OUT_CLOCK_SEL, 8'(f << 6));
			wait_launch(l);
			c0 = rise_count;
			repeat (2) wait_launch(l);
			`CHK(rise_count - c0, exp_rises[f])
		end
		wr(pxoca_pkg::OFS_OUT_CLOCK_SEL, 8'h00);
	endtask : t_forms
	task automatic t_sync;
		int l, n;
		n = 0;
		wr(pxoca_pkg::OFS_LINE_SYNC_WIDTH, 8'h03);
		// Off the rising edge so the pixel process cannot clear it at once
		@(negedge clk) hs_pend <= 1'b1;
		repeat (8) begin
			wait_launch(l);
			n += int'(line_sync_out);
		end
		`CHK(n, 3)
		wr(pxoca_pkg::OFS_LINE_SYNC_CTRL, 8'h01);
		wait_launch(l);
		`CHK(line_sync_out, 1'b1)
		repeat (2) @(posedge clk);
		#1;
		`CHK(cap_sync, line_sync_out)
		// Active-low input: the trailing pin edge starts the pulse
		wr(pxoca_pkg::OFS_LINE_SYNC_CTRL, 8'h02);
		n = 0;
		@(negedge clk) hs_pend <= 1'b1;
		repeat (8) begin
			wait_launch(l);
			n += int'(line_sync_out);
		end
		`CHK(n, 3)
		wr(pxoca_pkg::OFS_LINE_SYNC_CTRL, 8'h00);
	endtask : t_sync
	task automatic t_stall;
		int nv, nd, l;
		nv = 0;
		nd = 0;
		@(posedge clk) stall <= 1'b1;
		repeat (75) begin
			@(posedge clk);
			#1 nv += int'(out_valid);
			nd += int'(sample_dropped);
		end
		`CHK(nv, 0)
		`CHK(nd != 0, 1'b1)
		@(posedge clk) stall <= 1'b0;
		wait_launch(l);
		`CHK(out_valid, 1'b1)
	endtask : t_stall
	task automatic stop_test;
		if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_latency();
		t_forms();
		t_sync();
		t_stall();
		stop_test();
	end
endmodule : testbench
